//--- amr_core.v
/*
 * architectural register state and address generation for the core
 * assumes: all inputs come from logic on sys_clk_i; memory sits past ag_phys_o
 */
`timescale 1ns/1ps
`default_nettype none
`include "amr_regs.vh"

module amr_core (
  // clock and reset
  input wire sys_clk_i,
  input wire nrst_i,
  // mode and configuration
  input wire long_capable_i,
  input wire long_mode_i,
  input wire real_mode_i,
  input wire seg_model_i,
  input wire paging_en_i,
  input wire ext_xlate_en_i,
  input wire large_page_en_i,
  // general registers
  input wire gr_we_i,
  input wire [3:0] gr_widx_i,
  input wire [1:0] gr_wsize_i,
  input wire [63:0] gr_wdata_i,
  input wire [3:0] gr_ridx_i,
  input wire [1:0] gr_rsize_i,
  output reg [63:0] gr_rdata_o,
  // stack pointer
  input wire sp_adj_i,
  input wire [63:0] sp_delta_i,
  input wire ss_big_i,
  output reg [63:0] sp_o,
  // flags and instruction pointer
  input wire flag_we_i,
  input wire [63:0] flag_wdata_i,
  output reg [63:0] flag_o,
  input wire ip_we_i,
  input wire [1:0] ip_size_i,
  input wire [63:0] ip_wdata_i,
  output reg [63:0] ip_o,
  // system registers
  input wire sys_we_i,
  input wire [4:0] sys_sel_i,
  input wire [63:0] sys_wdata_i,
  input wire [15:0] sys_wlimit_i,
  input wire [4:0] sys_rsel_i,
  output reg [63:0] sys_rdata_o,
  output reg [15:0] sys_rlimit_o,
  output reg [3:0] task_priority_value_o,
  // vector registers
  input wire vec_we_i,
  input wire vec_wide_i,
  input wire [3:0] vec_idx_i,
  input wire [255:0] vec_wdata_i,
  input wire [3:0] vec_ridx_i,
  output reg [255:0] vec_rdata_o,
  // segment descriptors and page entries
  input wire seg_we_i,
  input wire [13:0] seg_idx_i,
  input wire [31:0] seg_base_i,
  input wire [31:0] seg_limit_i,
  input wire pg_we_i,
  input wire [2:0] pg_idx_i,
  input wire pg_valid_i,
  input wire pg_large_i,
  input wire [51:0] pg_vpn_i,
  input wire [33:0] pg_frame_i,
  // address generation
  input wire ag_req_i,
  input wire ag_stack_i,
  input wire [15:0] ag_sel_i,
  input wire [63:0] ag_off_i,
  output wire ag_vld_o,
  output wire [45:0] ag_phys_o,
  output wire [1:0] ag_flt_o,
  // identify query
  output reg [6:0] phys_width_o
);

  reg [63:0] gr_reg [0:`AMR_GR_NUM-1];
  reg [63:0] sys_reg [0:`AMR_SYS_NUM-1];
  reg [15:0] lim_reg [0:`AMR_SYS_NUM-1];
  reg [255:0] vec_reg [0:`AMR_VEC_NUM-1];
  reg [31:0] seg_base_reg [0:`AMR_SEG_NUM-1];
  reg [31:0] seg_lim_reg [0:`AMR_SEG_NUM-1];
  reg s1_vld_reg;
  reg [63:0] s1_lin_reg;
  reg [1:0] s1_flt_reg;
  reg [63:0] lin_next;
  reg [1:0] flt_next;
  reg [63:0] sp_next;
  reg [63:0] ip_next;
  wire eff_long;
  wire gr_wok;
  wire [1:0] sp_size;
  wire [1:0] flt_addr;
  wire [13:0] seg_idx;
  wire [31:0] seg_lin;
  wire [19:0] real_lin;
  wire canon_ok;
  wire [`AMR_PA_W-1:0] pa_mask;
  integer i;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // write-merge keeping the bits above the operand size
  function [63:0] amr_merge;
    input [63:0] old_v;
    input [63:0] new_v;
    input [1:0] sz;
    begin
      case (sz)
        `AMR_SZ_BYTE: amr_merge = {old_v[63:8], new_v[7:0]};
        `AMR_SZ_WORD: amr_merge = {old_v[63:16], new_v[15:0]};
        `AMR_SZ_DWORD: amr_merge = {old_v[63:32], new_v[31:0]};
        default: amr_merge = new_v;
      endcase
    end
  endfunction

  function [63:0] amr_trim;
    input [63:0] v;
    input [1:0] sz;
    begin
      case (sz)
        `AMR_SZ_BYTE: amr_trim = {56'h0, v[7:0]};
        `AMR_SZ_WORD: amr_trim = {48'h0, v[15:0]};
        `AMR_SZ_DWORD: amr_trim = {32'h0, v[31:0]};
        default: amr_trim = v;
      endcase
    end
  endfunction

  // which system selects exist in the current mode
  function amr_sys_ok;
    input [4:0] sel;
    input lm;
    begin
      if (sel <= `AMR_SYS_CTL_LAST) begin
        amr_sys_ok = 1'b1;
      end else if (sel == `AMR_SYS_TPC) begin
        amr_sys_ok = lm;
      end else if (sel >= `AMR_SYS_DBG_FIRST && sel <= `AMR_SYS_DBG_LAST) begin
        amr_sys_ok = 1'b1;
      end else if (sel >= `AMR_SYS_GDT && sel <= `AMR_SYS_TASK) begin
        amr_sys_ok = 1'b1;
      end else begin
        amr_sys_ok = 1'b0;
      end
    end
  endfunction

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // 64-bit mode only exists on a capable part
  assign eff_long = long_mode_i & long_capable_i;
  // legacy modes can write only the low eight general registers
  assign gr_wok = eff_long | ~gr_widx_i[3];
  assign sp_size = eff_long ? `AMR_SZ_QWORD :
                   (ss_big_i ? `AMR_SZ_DWORD : `AMR_SZ_WORD);
  assign pa_mask = long_capable_i ? {`AMR_PA_W{1'b1}} :
    {{(`AMR_PA_W-`AMR_PA_W_LEGACY){1'b0}}, {`AMR_PA_W_LEGACY{1'b1}}};

  // ----------------------------------------
  // linear address generation
  // ----------------------------------------
  assign canon_ok = (&ag_off_i[63:`AMR_CANON_MSB]) | ~(|ag_off_i[63:`AMR_CANON_MSB]);
  assign flt_addr = ag_stack_i ? `AMR_FLT_SS : `AMR_FLT_GP;
  assign seg_idx = ag_sel_i[15:2];
  assign seg_lin = seg_base_reg[seg_idx] + ag_off_i[31:0];
  // selector shifted four places, wrapping inside one megabyte
  assign real_lin = {ag_sel_i, 4'h0} + {4'h0, ag_off_i[15:0]};

  always @* begin
    lin_next = 64'h0;
    flt_next = `AMR_FLT_NONE;
    if (eff_long) begin
      lin_next = ag_off_i;
      if (!canon_ok) begin
        flt_next = flt_addr;
      end
    end else if (real_mode_i) begin
      lin_next = {44'h0, real_lin};
    end else if (seg_model_i) begin
      lin_next = {32'h0, seg_lin};
      // index zero is the null selector, leaving 16383 usable segments
      if (seg_idx == 14'h0) begin
        flt_next = `AMR_FLT_GP;
      end else if ((|ag_off_i[63:32]) ||
                   (ag_off_i[31:0] > seg_lim_reg[seg_idx])) begin
        flt_next = flt_addr;
      end
    end else begin
      lin_next = {32'h0, ag_off_i[31:0]};
    end
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_vld_reg <= 1'b0;
      s1_lin_reg <= 64'h0;
      s1_flt_reg <= `AMR_FLT_NONE;
    end else begin
      s1_vld_reg <= ag_req_i;
      if (ag_req_i) begin
        s1_lin_reg <= lin_next;
        s1_flt_reg <= flt_next;
      end
    end
  end

  // ----------------------------------------
  // paging stage
  // ----------------------------------------
  // 64-bit mode forces paging through the extended scheme; real mode never pages
  amr_xlate u_xlate (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .ld_we_i(pg_we_i),
    .ld_idx_i(pg_idx_i),
    .ld_valid_i(pg_valid_i),
    .ld_large_i(pg_large_i),
    .ld_vpn_i(pg_vpn_i),
    .ld_frame_i(pg_frame_i),
    .req_i(s1_vld_reg),
    .lin_i(s1_lin_reg),
    .flt_i(s1_flt_reg),
    .paging_i(eff_long | (paging_en_i & ~real_mode_i)),
    .ext_i(eff_long | ext_xlate_en_i),
    .large_en_i(large_page_en_i & ~eff_long),
    .pa_mask_i(pa_mask),
    .vld_o(ag_vld_o),
    .phys_o(ag_phys_o),
    .flt_o(ag_flt_o)
  );

  // ----------------------------------------
  // general registers and stack pointer
  // ----------------------------------------
  always @* begin
    sp_next = gr_reg[`AMR_SP_IDX];
    if (sp_adj_i) begin
      sp_next = amr_merge(gr_reg[`AMR_SP_IDX],
                          gr_reg[`AMR_SP_IDX] + sp_delta_i, sp_size);
    end
    // a direct write to the stack pointer beats an adjust in the same cycle
    if (gr_we_i && gr_wok && gr_widx_i == `AMR_SP_IDX) begin
      sp_next = amr_merge(gr_reg[`AMR_SP_IDX], gr_wdata_i,
                          (eff_long || gr_wsize_i != `AMR_SZ_QWORD) ? gr_wsize_i : `AMR_SZ_DWORD);
    end
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (i = 0; i < `AMR_GR_NUM; i = i + 1) begin
        gr_reg[i] <= 64'h0;
      end
      gr_rdata_o <= 64'h0;
      sp_o <= 64'h0;
    end else begin
      if (gr_we_i && gr_wok && gr_widx_i != `AMR_SP_IDX) begin
        gr_reg[gr_widx_i] <= amr_merge(gr_reg[gr_widx_i], gr_wdata_i,
          (eff_long || gr_wsize_i != `AMR_SZ_QWORD) ? gr_wsize_i : `AMR_SZ_DWORD);
      end
      gr_reg[`AMR_SP_IDX] <= sp_next;
      sp_o <= sp_next;
      gr_rdata_o <= amr_trim(gr_reg[gr_ridx_i], gr_rsize_i);
    end
  end

  // ----------------------------------------
  // flags and instruction pointer
  // ----------------------------------------
  always @* begin
    case (ip_size_i)
      `AMR_SZ_WORD: ip_next = {ip_o[63:16], ip_wdata_i[15:0]};
      `AMR_SZ_QWORD: ip_next = eff_long ? ip_wdata_i : {32'h0, ip_wdata_i[31:0]};
      default: ip_next = {32'h0, ip_wdata_i[31:0]};
    endcase
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_o <= 64'h0;
      ip_o <= 64'h0;
    end else begin
      if (flag_we_i) begin
        // upper half reserved: writes dropped, reads zero
        flag_o <= {32'h0, flag_wdata_i[`AMR_FLAG_LOW-1:0]};
      end
      if (ip_we_i) begin
        ip_o <= ip_next;
      end
    end
  end

  // ----------------------------------------
  // system registers
  // ----------------------------------------
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (i = 0; i < `AMR_SYS_NUM; i = i + 1) begin
        sys_reg[i] <= 64'h0;
        lim_reg[i] <= 16'h0;
      end
      sys_rdata_o <= 64'h0;
      sys_rlimit_o <= 16'h0;
      task_priority_value_o <= 4'h0;
      phys_width_o <= 7'h0;
    end else begin
      if (sys_we_i && amr_sys_ok(sys_sel_i, eff_long)) begin
        // legacy modes keep control and debug registers at 32 bits
        if (eff_long || sys_sel_i >= `AMR_SYS_GDT) begin
          sys_reg[sys_sel_i] <= sys_wdata_i;
        end else begin
          sys_reg[sys_sel_i] <= {32'h0, sys_wdata_i[31:0]};
        end
        lim_reg[sys_sel_i] <= sys_wlimit_i;
      end
      if (amr_sys_ok(sys_rsel_i, eff_long)) begin
        sys_rdata_o <= sys_reg[sys_rsel_i];
        sys_rlimit_o <= (sys_rsel_i >= `AMR_SYS_GDT) ? lim_reg[sys_rsel_i] : 16'h0;
      end else begin
        sys_rdata_o <= 64'h0;
        sys_rlimit_o <= 16'h0;
      end
      task_priority_value_o <= eff_long ? sys_reg[`AMR_SYS_TPC][3:0] : 4'h0;
      phys_width_o <= long_capable_i ? 7'd`AMR_PA_W : 7'd`AMR_PA_W_LEGACY;
    end
  end

  // ----------------------------------------
  // vector registers, descriptors
  // ----------------------------------------
  // bulk data arrays: no reset, software loads them before use
  always @(posedge sys_clk_i) begin
    if (vec_we_i && (eff_long || !vec_idx_i[3])) begin
      if (vec_wide_i) begin
        vec_reg[vec_idx_i] <= vec_wdata_i;
      end else begin
        vec_reg[vec_idx_i] <= {vec_reg[vec_idx_i][255:128], vec_wdata_i[127:0]};
      end
    end
    if (seg_we_i) begin
      seg_base_reg[seg_idx_i] <= seg_base_i;
      seg_lim_reg[seg_idx_i] <= seg_limit_i;
    end
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vec_rdata_o <= 256'h0;
    end else begin
      vec_rdata_o <= (eff_long || !vec_ridx_i[3]) ? vec_reg[vec_ridx_i] : 256'h0;
    end
  end

endmodule

`default_nettype wire

//--- amr_core_sva.sv
/*
 * checker for amr_core address answers and register views
 * assumes: bound to amr_core, one clock domain, async active-low reset
 */
`timescale 1ns/1ps
`default_nettype none
module amr_core_sva (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // modes
  input wire logic long_capable_i,
  input wire logic long_mode_i,
  input wire logic real_mode_i,
  input wire logic seg_model_i,
  input wire logic paging_en_i,
  // register views
  input wire logic [1:0] gr_rsize_i,
  input wire logic [63:0] gr_rdata_o,
  input wire logic [63:0] flag_o,
  input wire logic [6:0] phys_width_o,
  // address generation
  input wire logic ag_req_i,
  input wire logic ag_stack_i,
  input wire logic [15:0] ag_sel_i,
  input wire logic [63:0] ag_off_i,
  input wire logic ag_vld_o,
  input wire logic [45:0] ag_phys_o,
  input wire logic [1:0] ag_flt_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  wire lm = long_capable_i & long_mode_i;
  wire canon = (&ag_off_i[63:47]) | ~(|ag_off_i[63:47]);

  property p_ag_lat;
    ag_req_i |-> ##2 ag_vld_o;
  endproperty
  a_ag_lat: assert property (p_ag_lat) else $error("address answer late");
  property p_flag_hi;
    flag_o[63:32] == 32'h0;
  endproperty
  a_flag_hi: assert property (p_flag_hi) else $error("flag upper half set");
  property p_width;
    nrst_i |=> phys_width_o == ($past(long_capable_i) ? 7'd46 : 7'd36);
  endproperty
  a_width: assert property (p_width) else $error("physical width wrong");
  property p_flt_zero;
    ag_vld_o && ag_flt_o != 2'h0 |-> ag_phys_o == 46'h0;
  endproperty
  a_flt_zero: assert property (p_flt_zero) else $error("faulted address not zero");
  property p_canon;
    ag_req_i && lm && !canon |-> ##2 ag_flt_o == ($past(ag_stack_i, 2) ? 2'h2 : 2'h1);
  endproperty
  a_canon: assert property (p_canon) else $error("canonical fault wrong");
  property p_flat;
    ag_req_i && !lm && !real_mode_i && !seg_model_i && !paging_en_i
      |-> ##2 ag_phys_o == {14'h0, $past(ag_off_i[31:0], 2)} && ag_flt_o == 2'h0;
  endproperty
  a_flat: assert property (p_flat) else $error("direct map wrong");
  property p_real;
    ag_req_i && !lm && real_mode_i |-> ##2
      ag_phys_o == {26'h0, ({$past(ag_sel_i, 2), 4'h0} + {4'h0, $past(ag_off_i[15:0], 2)})};
  endproperty
  a_real: assert property (p_real) else $error("real address wrong");
  property p_byte_rd;
    gr_rsize_i == 2'h0 |=> gr_rdata_o[63:8] == 56'h0;
  endproperty
  a_byte_rd: assert property (p_byte_rd) else $error("byte read not low 8 bits");
endmodule
bind amr_core amr_core_sva u_amr_core_sva (.*);
`default_nettype wire

//--- amr_mem_model.sv
/*
 * physical memory seen past the address generator: one byte per address
 * assumes: answers each fault-free ag_vld_o pulse on the next edge
 */
`timescale 1ns/1ps
`default_nettype none
module amr_mem_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // address from the core
  input wire logic vld_i,
  input wire logic [45:0] phys_i,
  input wire logic [1:0] flt_i,
  // read view
  output var logic [7:0] rdata_o,
  output var logic [15:0] acc_cnt_o
);
  // faulted answers carry no address, so they never reach memory
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
      acc_cnt_o <= 16'h0000;
    end else if (vld_i && flt_i == 2'h0) begin
      acc_cnt_o <= acc_cnt_o + 16'h0001;
      rdata_o <= phys_i[7:0] ^ phys_i[15:8] ^ 8'h5a;
    end
  end
endmodule
`default_nettype wire

//--- amr_regs.vh
/*
 * widths, indices, codes and select values shared by the address model core
 * assumes: included by its bare name from the design files, definitions only
 */
`ifndef AMR_REGS_VH
`define AMR_REGS_VH

// ----------------------------------------
// register widths and counts
// ----------------------------------------
`define AMR_XLEN 64
`define AMR_GR_NUM 16
`define AMR_GR_LEGACY 8
`define AMR_FLAG_LOW 32
`define AMR_SP_IDX 4'h4
`define AMR_VEC_W 256
`define AMR_VEC_LO 128
`define AMR_VEC_NUM 16
`define AMR_LIM_W 16

// ----------------------------------------
// address widths
// ----------------------------------------
`define AMR_PA_W 46
`define AMR_PA_W_LEGACY 36
`define AMR_PA_W_NOEXT 32
`define AMR_CANON_MSB 47
`define AMR_FLAT_W 32
`define AMR_REAL_W 20
`define AMR_SEG_IDX_W 14
`define AMR_SEG_NUM 16384
`define AMR_PG_SHIFT 12
`define AMR_LPG_SHIFT 22
`define AMR_TLB_N 8
`define AMR_TLB_IDX_W 3

// ----------------------------------------
// operand size codes
// ----------------------------------------
`define AMR_SZ_BYTE 2'h0
`define AMR_SZ_WORD 2'h1
`define AMR_SZ_DWORD 2'h2
`define AMR_SZ_QWORD 2'h3

// ----------------------------------------
// system register selects
// ----------------------------------------
`define AMR_SYS_CTL_LAST 5'h04
`define AMR_SYS_TPC 5'h05
`define AMR_SYS_DBG_FIRST 5'h08
`define AMR_SYS_DBG_LAST 5'h0f
`define AMR_SYS_GDT 5'h10
`define AMR_SYS_TASK 5'h13
`define AMR_SYS_NUM 20

// ----------------------------------------
// fault codes
// ----------------------------------------
`define AMR_FLT_NONE 2'h0
`define AMR_FLT_GP 2'h1
`define AMR_FLT_SS 2'h2
`define AMR_FLT_PAGE 2'h3

`endif

//--- amr_xlate.v
/*
 * paging stage: linear to physical through a small associative page table
 * assumes: fed one registered linear address per cycle by the core
 */
`timescale 1ns/1ps
`default_nettype none
`include "amr_regs.vh"

module amr_xlate (
  // clock and reset
  input wire sys_clk_i,
  input wire nrst_i,
  // page entry load
  input wire ld_we_i,
  input wire [`AMR_TLB_IDX_W-1:0] ld_idx_i,
  input wire ld_valid_i,
  input wire ld_large_i,
  input wire [51:0] ld_vpn_i,
  input wire [33:0] ld_frame_i,
  // request
  input wire req_i,
  input wire [63:0] lin_i,
  input wire [1:0] flt_i,
  input wire paging_i,
  input wire ext_i,
  input wire large_en_i,
  input wire [`AMR_PA_W-1:0] pa_mask_i,
  // answer
  output reg vld_o,
  output reg [`AMR_PA_W-1:0] phys_o,
  output reg [1:0] flt_o
);

  reg [`AMR_TLB_N-1:0] ent_v_reg;
  reg [`AMR_TLB_N-1:0] ent_l_reg;
  reg [51:0] ent_vpn_reg [0:`AMR_TLB_N-1];
  reg [33:0] ent_frm_reg [0:`AMR_TLB_N-1];
  wire [`AMR_TLB_N-1:0] hit;
  reg [`AMR_PA_W-1:0] pg_phys;
  reg found;
  reg [`AMR_PA_W-1:0] eff_mask;
  integer i;

  // ----------------------------------------
  // lookup
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `AMR_TLB_N; gi = gi + 1) begin : g_hit
      assign hit[gi] = ent_v_reg[gi] & (ent_l_reg[gi] ?
        (large_en_i & (lin_i[63:`AMR_LPG_SHIFT] == ent_vpn_reg[gi][51:10])) :
        (lin_i[63:`AMR_PG_SHIFT] == ent_vpn_reg[gi]));
    end
  endgenerate

  always @* begin
    pg_phys = {`AMR_PA_W{1'b0}};
    found = 1'b0;
    for (i = 0; i < `AMR_TLB_N; i = i + 1) begin
      if (hit[i] && !found) begin
        found = 1'b1;
        if (ent_l_reg[i]) begin
          pg_phys = {ent_frm_reg[i][33:10], lin_i[21:0]};
        end else begin
          pg_phys = {ent_frm_reg[i], lin_i[11:0]};
        end
      end
    end
    // without the extended option frames stop at 4 gigabytes
    eff_mask = ext_i ? pa_mask_i : {{(`AMR_PA_W-`AMR_PA_W_NOEXT){1'b0}}, 32'hffffffff};
  end

  // ----------------------------------------
  // table and answer
  // ----------------------------------------
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ent_v_reg <= {`AMR_TLB_N{1'b0}};
      ent_l_reg <= {`AMR_TLB_N{1'b0}};
      vld_o <= 1'b0;
      phys_o <= {`AMR_PA_W{1'b0}};
      flt_o <= `AMR_FLT_NONE;
    end else begin
      if (ld_we_i) begin
        ent_v_reg[ld_idx_i] <= ld_valid_i;
        ent_l_reg[ld_idx_i] <= ld_large_i;
      end
      vld_o <= req_i;
      if (req_i) begin
        if (flt_i != `AMR_FLT_NONE) begin
          flt_o <= flt_i;
          phys_o <= {`AMR_PA_W{1'b0}};
        end else if (paging_i && !found) begin
          flt_o <= `AMR_FLT_PAGE;
          phys_o <= {`AMR_PA_W{1'b0}};
        end else if (paging_i) begin
          flt_o <= `AMR_FLT_NONE;
          phys_o <= pg_phys & eff_mask;
        end else begin
          flt_o <= `AMR_FLT_NONE;
          phys_o <= lin_i[`AMR_PA_W-1:0] & eff_mask;
        end
      end
    end
  end

  // entry contents carry no control meaning, so they skip the reset
  always @(posedge sys_clk_i) begin
    if (ld_we_i) begin
      ent_vpn_reg[ld_idx_i] <= ld_vpn_i;
      ent_frm_reg[ld_idx_i] <= ld_frame_i;
    end
  end

endmodule

`default_nettype wire

//--- tb_top.sv
/*
 * self-checking bench for amr_core with a byte memory past the address port
 * assumes: amr_core and amr_core_sva compiled alongside, 4 ns clock
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic sys_clk_i = 1'b0, nrst_i = 1'b0, long_capable_i = 1'b1, long_mode_i = 1'b1;
  logic real_mode_i = 1'b0, seg_model_i = 1'b0, paging_en_i = 1'b0, ext_xlate_en_i = 1'b0;
  logic large_page_en_i = 1'b0, gr_we_i = 1'b0, sp_adj_i = 1'b0, ss_big_i = 1'b0;
  logic flag_we_i = 1'b0, ip_we_i = 1'b0, sys_we_i = 1'b0, vec_we_i = 1'b0, vec_wide_i = 1'b1;
  logic seg_we_i = 1'b0, pg_we_i = 1'b0, pg_valid_i = 1'b1, pg_large_i = 1'b0;
  logic ag_req_i = 1'b0, ag_stack_i = 1'b0, ag_vld_o;
  logic [3:0] gr_widx_i = 4'h0, gr_ridx_i = 4'h0, vec_idx_i = 4'h0, vec_ridx_i = 4'h0;
  logic [1:0] gr_wsize_i = 2'h0, gr_rsize_i = 2'h0, ip_size_i = 2'h3, ag_flt_o;
  logic [63:0] gr_wdata_i = 64'h0, sp_delta_i = 64'h0, flag_wdata_i = 64'h0, ip_wdata_i = 64'h0;
  logic [63:0] sys_wdata_i = 64'h0, ag_off_i = 64'h0, gr_rdata_o, sp_o, flag_o, ip_o, sys_rdata_o;
  logic [4:0] sys_sel_i = 5'h0, sys_rsel_i = 5'h0;
  logic [15:0] sys_wlimit_i = 16'h0, ag_sel_i = 16'h0, sys_rlimit_o, mem_cnt;
  logic [255:0] vec_wdata_i = 256'h0, vec_rdata_o;
  logic [13:0] seg_idx_i = 14'h5;
  logic [31:0] seg_base_i = 32'h1000_0000, seg_limit_i = 32'hff;
  logic [2:0] pg_idx_i = 3'h0;
  logic [51:0] pg_vpn_i = 52'h0;
  logic [33:0] pg_frame_i = 34'h0;
  logic [3:0] task_priority_value_o;
  logic [45:0] ag_phys_o;
  logic [6:0] phys_width_o;
  logic [7:0] mem_rdata;
  int err_total = 0, num_checks = 0;

  always #2 sys_clk_i = ~sys_clk_i;
  amr_core u_amr_core (.*);
  amr_mem_model u_amr_mem_model (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .vld_i(ag_vld_o),
    .phys_i(ag_phys_o), .flt_i(ag_flt_o), .rdata_o(mem_rdata), .acc_cnt_o(mem_cnt));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [255:0] exp, input logic [255:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // answer must come on the second edge; a lost answer ends the run
  task automatic ag(input [15:0] sel, input [63:0] off, input st, input [45:0] ep, input [1:0] ef);
    int n;
    ag_sel_i = sel;
    ag_off_i = off;
    ag_stack_i = st;
    ag_req_i = 1'b1;
    cyc();
    ag_req_i = 1'b0;
    n = 1;
    while (ag_vld_o !== 1'b1 && n < 8) begin
      cyc();
      n++;
    end
    if (n == 8) begin
      err_total++;
      close_out();
    end
    chk("ag_lat", 2, n);
    chk("ag_phys", ep, ag_phys_o);
    chk("ag_flt", ef, ag_flt_o);
  endtask
  task automatic pg(input [2:0] idx, input lg, input [51:0] vpn, input [33:0] frm);
    pg_idx_i = idx;
    pg_large_i = lg;
    pg_vpn_i = vpn;
    pg_frame_i = frm;
    pg_we_i = 1'b1;
    cyc();
    pg_we_i = 1'b0;
    cyc();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    gr_we_i = 1'b1;
    gr_widx_i = 4'h9;
    gr_wsize_i = 2'h3;
    gr_wdata_i = 64'h0123_4567_89ab_cdef;
    flag_we_i = 1'b1;
    flag_wdata_i = 64'hffff_ffff_ffff_ffff;
    ip_we_i = 1'b1;
    ip_wdata_i = 64'hfedc_ba98_7654_3210;
    vec_we_i = 1'b1;
    vec_idx_i = 4'hf;
    vec_wdata_i = {4{64'h0f1e_2d3c_4b5a_6978}};
    cyc();
    {flag_we_i, vec_we_i} = 2'b00;
    gr_wsize_i = 2'h0;
    gr_wdata_i = 64'hffff_ffff_ffff_ff5a;
    ip_size_i = 2'h1;
    ip_wdata_i = 64'hffff_ffff_ffff_1111;
    cyc();
    {gr_we_i, ip_we_i} = 2'b00;
    gr_ridx_i = 4'h9;
    gr_rsize_i = 2'h3;
    vec_ridx_i = 4'hf;
    cyc(2);
    chk("gr_q", 64'h0123_4567_89ab_cd5a, gr_rdata_o);
    chk("flag", 64'hffff_ffff, flag_o);
    chk("ip", 64'hfedc_ba98_7654_1111, ip_o);
    chk("vec", {4{64'h0f1e_2d3c_4b5a_6978}}, vec_rdata_o);
    gr_rsize_i = 2'h0;
    cyc();
    chk("gr_b", 64'h5a, gr_rdata_o);
    chk("pwidth", 46, phys_width_o);
  endtask
  task automatic t_sp(input [63:0] esp);
    gr_we_i = 1'b1;
    gr_widx_i = 4'h4;
    gr_wsize_i = 2'h3;
    gr_wdata_i = 64'h0000_0001_0000_fff0;
    cyc();
    gr_we_i = 1'b0;
    sp_adj_i = 1'b1;
    sp_delta_i = 64'h20;
    cyc();
    sp_adj_i = 1'b0;
    cyc(3);
    chk("sp", esp, sp_o);
  endtask
  task automatic t_sys(input [4:0] sel, input [63:0] d, input [15:0] lim, input [15:0] elim);
    sys_sel_i = sel;
    sys_wdata_i = d;
    sys_wlimit_i = lim;
    sys_we_i = 1'b1;
    cyc();
    sys_we_i = 1'b0;
    sys_rsel_i = sel;
    cyc(2);
    chk("sys", d, sys_rdata_o);
    chk("sys_lim", elim, sys_rlimit_o);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(5);
    nrst_i = 1'b1;
    t_regs();
    t_sp(64'h0000_0001_0001_0010);
    t_sys(5'h05, 64'h3c, 16'h0, 16'h0);
    chk("tpv", 4'hc, task_priority_value_o);
    t_sys(5'h08, 64'hdead_beef_0000_0001, 16'h0, 16'h0);
    t_sys(5'h10, 64'hffff_8000_1234_5678, 16'h0fff, 16'h0fff);
    pg(3'h0, 1'b0, 52'h7_fff1_2345, 34'h2_0000_abcd);
    pg(3'h1, 1'b1, 52'h400, 34'hc00);
    pg(3'h2, 1'b0, 52'h401, 34'h2_0000_0001);
    ag(0, 64'h0000_7fff_1234_5678, 0, 46'h2000_0abc_d678, 0);
    ag(0, 64'h0000_8000_0000_0000, 0, 0, 1);
    ag(0, 64'hffff_7fff_0000_0000, 1, 0, 2);
    ag(0, 64'h0040_0000, 0, 0, 3);
    long_mode_i = 1'b0;
    ag(0, 64'h1234_89ab_cdef, 0, 46'h89ab_cdef, 0);
    real_mode_i = 1'b1;
    ag(16'hffff, 64'h20, 0, 46'h10, 0);
    {real_mode_i, seg_we_i, seg_model_i} = 3'b011;
    cyc();
    seg_we_i = 1'b0;
    ag(16'h0014, 64'h10, 0, 46'h1000_0010, 0);
    ag(16'h0014, 64'h100, 1, 0, 2);
    ag(16'h0000, 64'h10, 0, 0, 1);
    {seg_model_i, paging_en_i, large_page_en_i} = 3'b011;
    ag(0, 64'h0040_1234, 0, 46'h00c0_1234, 0);
    {large_page_en_i, ext_xlate_en_i} = 2'b01;
    ag(0, 64'h0040_1234, 0, 46'h2000_0000_1234, 0);
    // a part without 64-bit support cuts the same frame to 36 bits
    long_capable_i = 1'b0;
    ag(0, 64'h0040_1234, 0, 46'h0000_0000_1234, 0);
    chk("pwidth36", 36, phys_width_o);
    // outside 64-bit mode the descriptor bit picks a 16-bit stack
    t_sp(64'h0000_0001_0000_0010);
    cyc();
    chk("mem_cnt", 7, mem_cnt);
    chk("mem_byte", 8'h7c, mem_rdata);
    close_out();
  end
endmodule
`default_nettype wire
